// ==== bench/cmc_dev_model.sv ====
// Behavioural transceiver: mode pins, sleep timer, wake filters, data path
`timescale 1ns/1ps
module cmc_dev_model #(parameter int HOLD = 4, parameter int WAKE_FILT = 3) (
  // Pins
  input wire logic clk_i, en_i, stby_n_i, txd_i, bus_dom_i, wake_i,
  // Supply status
  input wire logic sup_i, vbat_ok_i,
  output logic rxd_o, fault_flag_n_o
);
  int mode = 2;
  int t = 0;
  int bt = 0;
  int lt = 0;
  logic wflag = 0;
  logic dom_q = 0;
  logic wk_q = 0;
  wire dom = bus_dom_i || (mode == 0 && !txd_i);
  wire bus_wake = bt == WAKE_FILT;
  wire loc_wake = lt >= WAKE_FILT && wake_i != wk_q;
  wire ev = (bus_wake || loc_wake) && mode > 1;
  always @(posedge clk_i) begin
    t <= (mode == 3) ? t + 1 : 0;
    dom_q <= bus_dom_i;
    bt <= !bus_dom_i ? 0 : (!dom_q || bt > 0) ? bt + 1 : 0;
    lt <= (wake_i == wk_q || loc_wake) ? 0 : lt + 1;
    if (loc_wake) wk_q <= wake_i;
    if (ev) wflag <= 1;
    if (!vbat_ok_i) mode <= 2;
    else if (!sup_i) mode <= 4;
    else if (ev && mode == 4) mode <= 2;
    else if (en_i && stby_n_i) mode <= 0;
    else if (stby_n_i) mode <= 1;
    else if (en_i && mode != 4) mode <= (mode == 3 && t >= HOLD) ? 4 : 3;
    else if (!en_i && mode != 4) mode <= 2;
    if (en_i && stby_n_i && sup_i) wflag <= 0;
  end
  assign rxd_o = (mode < 2) ? !dom : !(wflag && sup_i);
  assign fault_flag_n_o = (mode < 2) ? 1'b1 : !(wflag && sup_i);
endmodule : cmc_dev_model

// ==== bench/cmc_host_sva.sv ====
// Port checker for the mode controller
`timescale 1ns/1ps
module cmc_host_sva import cmc_pkg::*; (
  // Clock, reset, bus and pins
  input wire logic clk_sys_i, reset_i, psel_i, penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o, pslverr_o, mode_sel_o, standby_ctrl_n_o, txd_o, rxd_ctrl_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire setup = psel_i && !penable_i;
  wire mapped = paddr_i inside {CMC_CTRL_OFS, CMC_STAT_OFS, CMC_HOLD_OFS};
  property p_rdy; setup |=> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_one; pready_o |=> !pready_o; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; setup && !mapped |=> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("slave error missing");
  property p_ok; setup && mapped |=> !pslverr_o; endproperty
  a_ok: assert property (p_ok) else $error("slave error on mapped address");
  property p_gts; $fell(standby_ctrl_n_o) |-> $stable(mode_sel_o); endproperty
  a_gts: assert property (p_gts) else $error("enable moved as standby fell");
  property p_enf; $fell(mode_sel_o) |-> $stable(standby_ctrl_n_o); endproperty
  a_enf: assert property (p_enf) else $error("standby moved as enable fell");
  property p_tx; (!mode_sel_o || !standby_ctrl_n_o) [*8] |-> txd_o; endproperty
  a_tx: assert property (p_tx) else $error("transmit not blocked");
  property p_rx; !standby_ctrl_n_o [*8] |-> rxd_ctrl_o; endproperty
  a_rx: assert property (p_rx) else $error("receive not held high");
  c_err: cover property (setup && !mapped ##1 pslverr_o);
  c_gts: cover property (mode_sel_o && !standby_ctrl_n_o [*4]);
  c_tx: cover property (mode_sel_o && standby_ctrl_n_o && !txd_o);
endmodule : cmc_host_sva

// ==== bench/cmc_host_tb.sv ====
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module cmc_host_tb;
  import cmc_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, sup = 1, txc = 1;
  logic bus_dom = 0, wake = 0, vbat = 1, err, prdy, perr, en, stn, txd, rxc, rxd, ffn;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, lfsr = 32'hc2e7_1eb2;
  logic [2:0] cmds [6] = '{CMC_CMD_SLEEP, CMC_CMD_NORMAL, CMC_CMD_RXONLY,
                           CMC_CMD_STANDBY, CMC_CMD_SLEEP, CMC_CMD_NORMAL};
  int fail_count = 0, n_tests = 0, m;
  initial forever #50 clk_sys_i = ~clk_sys_i;
  cmc_host DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .supplies_ok_i(sup), .mode_sel_o(en), .standby_ctrl_n_o(stn),
    .fault_flag_n_i(ffn), .rxd_i(rxd), .txd_ctrl_i(txc), .txd_o(txd), .rxd_ctrl_o(rxc));
  cmc_dev_model #(.HOLD(4)) u_dev (.clk_i(clk_sys_i), .en_i(en), .stby_n_i(stn),
    .txd_i(txd), .bus_dom_i(bus_dom), .wake_i(wake), .sup_i(sup), .vbat_ok_i(vbat),
    .rxd_o(rxd), .fault_flag_n_o(ffn));
  function automatic logic [31:0] nxt_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt_rand
  function automatic int exp_mode(input logic [2:0] c);
    return (c == CMC_CMD_NORMAL) ? 0 : (c == CMC_CMD_RXONLY) ? 1 : (c == CMC_CMD_SLEEP) ? 4 : 2;
  endfunction : exp_mode
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys_i);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    @(posedge clk_sys_i);
    while (prdy !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (prdy !== 1'b1) fail_count++;
    rd = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic go(input logic [2:0] c);
    int n = 0;
    apb(1, CMC_CTRL_OFS, 32'(c) | 32'h0000_0010);
    apb(0, CMC_STAT_OFS, 0);
    while (rd[0] !== 1'b0 && n < 700) begin
      apb(0, CMC_STAT_OFS, 0);
      n++;
    end
    if (rd[0] !== 1'b0) fail_count++;
  endtask : go
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #2_000_000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    chk("reset pins", 32'h0000_0003, 32'({en, stn, txd, rxc}));
    reset_i <= 0;
    apb(0, CMC_HOLD_OFS, 0);
    chk("hold reset", 32'(CMC_HOLD_RST), rd & 32'h0000_ffff);
    apb(1, CMC_HOLD_OFS, 4);
    apb(0, CMC_HOLD_OFS, 0);
    chk("hold", 32'h0000_0004, rd & 32'h0000_ffff);
    apb(0, 8'h0c, 0);
    chk("slverr", 32'h0000_0001, 32'(err));
    foreach (cmds[i]) begin
      m = exp_mode(cmds[i]);
      go(cmds[i]);
      chk("pins", 32'({m == 0, m < 2}), 32'({en, stn}));
      chk("mode", 32'(m), 32'(u_dev.mode));
      chk("mode field", 32'(cmds[i]), 32'(rd[5:3]));
      repeat (4) begin
        lfsr = nxt_rand(lfsr);
        txc <= lfsr[0];
        bus_dom <= lfsr[1];
        repeat (5) @(posedge clk_sys_i);
        chk("txd", 32'(m == 0 ? txc : 1'b1), 32'(txd));
        chk("rxd", 32'(m < 2 ? !(bus_dom || (m == 0 && !txc)) : 1'b1), 32'(rxc));
      end
    end
    sup <= 0;
    repeat (3) @(posedge clk_sys_i);
    go(CMC_CMD_RXONLY);
    chk("no supply", 32'h0000_0003, 32'({en, stn}));
    sup <= 1;
    go(CMC_CMD_SLEEP);
    wake <= 1;
    repeat (8) @(posedge clk_sys_i);
    apb(0, CMC_STAT_OFS, 0);
    chk("wake", 32'h0000_0001, 32'(rd[1]));
    go(CMC_CMD_NORMAL);
    apb(1, CMC_CTRL_OFS, 32'h0000_0020);
    apb(0, CMC_STAT_OFS, 0);
    chk("wake clear", 32'h0000_0000, 32'(rd[1]));
    chk("fault", 32'h0000_0000, 32'(rd[2]));
    give_verdict();
  end
endmodule : cmc_host_tb
bind cmc_host cmc_host_sva u_sva (.*);

// ==== rtl/cmc_host.sv ====
// Host controller that drives the transceiver mode pins, with APB registers
//
// Function
// RQ1: Pins only change mode while all three supplies are present; host drops a go command while supplies are absent.
// RQ2: EN high and standby high selects Normal; host drives both high.
// RQ3: Receive output low for dominant, high for recessive in active modes.
// RQ4: EN low, standby high selects Receive-Only; transmit blocked.
// RQ5: Wake receivers and local wake input inactive in Normal and Receive-Only.
// RQ6: Normal reports all failures on fault flag; Receive-Only only local ones.
// RQ7: Device enters Stand-By after power-up with no pin action.
// RQ8: Stand-By disables driver, receiver, diagnostics; wake flag set on bus.
// RQ9: Stand-By shows a wake event on receive output and fault flag.
// RQ10: Stand-By local wake reported on receive output and fault flag.
// RQ11: Stand-By power-up event reported on fault flag.
// RQ12: Both pins low from Normal or Receive-Only gives Stand-By.
// RQ13: Battery undervoltage forces Stand-By from any mode.
// RQ14: Standby low with EN high starts Go-To-Sleep.
// RQ15: Go-To-Sleep disables data path; wake inputs active, inhibit asserted.
// RQ16: Go-To-Sleep lasts the hold time, then Sleep.
// RQ17: EN falling before hold time gives Stand-By, inhibit kept.
// RQ18: EN falling after hold time gives Sleep, inhibit floats.
// RQ19: Sleep reached by pins only through Go-To-Sleep.
// RQ20: Bus wake in Sleep gives Stand-By and sets wake flag.
// RQ21: Local wake change in Sleep gives Stand-By.
// RQ22: Transceiver or logic undervoltage gives Sleep.
// RQ23: Bus wake needs recessive-to-dominant then long dominant.
// RQ24: Local wake triggers on both edges, filtered.
// RQ25: Hold and filter times are counters restarted at each qualifying edge.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cmc_host import cmc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Supply status of the transceiver
  input wire logic supplies_ok_i,
  // Transceiver control pins
  output logic mode_sel_o,
  output logic standby_ctrl_n_o,
  // Transceiver status pins
  input wire logic fault_flag_n_i,
  input wire logic rxd_i,
  // CAN controller transmit and receive path
  input wire logic txd_ctrl_i,
  output logic txd_o,
  output logic rxd_ctrl_o
);
  cmc_state_t state_ff;
  cmc_state_t nxt_state;
  logic [2:0] cmd_ff;
  logic [2:0] cur_mode_ff;
  logic [15:0] hold_ff;
  logic [15:0] cnt_ff;
  logic wake_ff;
  logic fault_ff;
  logic busy_ff;
  logic [1:0] sup_sync_ff;
  logic [1:0] flt_sync_ff;
  logic [1:0] rxd_sync_ff;
  logic wr_acc;
  logic go;
  logic active_mode;

  assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
  assign go = wr_acc && paddr_i == CMC_CTRL_OFS && pwdata_i[CMC_CTRL_GO_POS] && !busy_ff;
  assign active_mode = cur_mode_ff == CMC_CMD_NORMAL || cur_mode_ff == CMC_CMD_RXONLY;

  // Pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    sup_sync_ff <= {sup_sync_ff[0], supplies_ok_i};
    flt_sync_ff <= {flt_sync_ff[0], fault_flag_n_i};
    rxd_sync_ff <= {rxd_sync_ff[0], rxd_i};
  end

  // APB: zero wait state, error on unmapped address
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & paddr_i != CMC_CTRL_OFS &
                   paddr_i != CMC_STAT_OFS & paddr_i != CMC_HOLD_OFS;
      case (paddr_i)
        CMC_CTRL_OFS: prdata_o <= {29'h000_0000, cmd_ff};
        CMC_STAT_OFS: prdata_o <= {21'h0_0000, state_ff, cur_mode_ff,
                                   fault_ff, wake_ff, busy_ff};
        CMC_HOLD_OFS: prdata_o <= {16'h0000, hold_ff};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Command and hold registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_ff <= CMC_CMD_STANDBY;
      hold_ff <= CMC_HOLD_RST;
    end else if (wr_acc) begin
      if (paddr_i == CMC_CTRL_OFS && !busy_ff) begin
        cmd_ff <= pwdata_i[CMC_CTRL_CMD_POS +: 3];
      end
      if (paddr_i == CMC_HOLD_OFS) begin
        hold_ff <= pwdata_i[15:0];
      end
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CMC_IDLE: if (go && sup_sync_ff[1]) nxt_state = CMC_STANDBY_CTRL_N_LOW; // RQ1
      CMC_STANDBY_CTRL_N_LOW: nxt_state = CMC_HOLD;
      CMC_HOLD: if (cnt_ff == 16'h0000) nxt_state = CMC_EN_LOW;
      CMC_EN_LOW: nxt_state = CMC_DONE;
      CMC_DONE: nxt_state = CMC_IDLE;
      default: nxt_state = CMC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_ff <= CMC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hold counter, restarted on entry to Go-To-Sleep
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_ff <= 16'h0000;
    end else if (state_ff == CMC_STANDBY_CTRL_N_LOW) begin
      if (cmd_ff == CMC_CMD_SLEEP) begin
        cnt_ff <= 16'(hold_ff + CMC_MARGIN_CYC); // RQ16 RQ18 RQ25
      end else begin
        cnt_ff <= 16'h0000; // RQ17
      end
    end else if (cnt_ff != 16'h0000) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  // Mode pins; reset leaves both low so device stays in Stand-By
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_sel_o <= 1'b0; // RQ7
      standby_ctrl_n_o <= 1'b0;
      cur_mode_ff <= CMC_CMD_STANDBY;
    end else if (state_ff == CMC_IDLE && go && sup_sync_ff[1]) begin
      case (pwdata_i[CMC_CTRL_CMD_POS +: 3])
        CMC_CMD_NORMAL: begin
          mode_sel_o <= 1'b1; // RQ2
          standby_ctrl_n_o <= 1'b1;
        end
        CMC_CMD_RXONLY: begin
          mode_sel_o <= 1'b0; // RQ4
          standby_ctrl_n_o <= 1'b1;
        end
        default: begin
          mode_sel_o <= 1'b1; // RQ14 RQ19
          standby_ctrl_n_o <= 1'b1;
        end
      endcase
    end else if (state_ff == CMC_STANDBY_CTRL_N_LOW) begin
      standby_ctrl_n_o <= 1'b0; // RQ14
    end else if (state_ff == CMC_EN_LOW) begin
      mode_sel_o <= 1'b0; // RQ12 RQ17 RQ18
      cur_mode_ff <= cmd_ff;
    end else if (state_ff == CMC_DONE && (cmd_ff == CMC_CMD_NORMAL || cmd_ff == CMC_CMD_RXONLY)) begin
      mode_sel_o <= cmd_ff == CMC_CMD_NORMAL;
      standby_ctrl_n_o <= 1'b1;
    end
  end

  // Busy flag covers the whole pin sequence
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_state != CMC_IDLE;
    end
  end

  // Sticky wake and fault indications; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wake_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      if (!active_mode && !flt_sync_ff[1]) begin
        wake_ff <= 1'b1; // RQ9 RQ10 RQ11
      end else if (wr_acc && paddr_i == CMC_CTRL_OFS && pwdata_i[CMC_CTRL_CLRW_POS]) begin
        wake_ff <= 1'b0;
      end
      if (active_mode && !flt_sync_ff[1]) begin
        fault_ff <= 1'b1; // RQ6
      end else if (wr_acc && paddr_i == CMC_CTRL_OFS && pwdata_i[CMC_CTRL_CLRW_POS]) begin
        fault_ff <= 1'b0;
      end
    end
  end

  // Data path to the CAN controller
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      txd_o <= 1'b1;
      rxd_ctrl_o <= 1'b1;
    end else begin
      txd_o <= (cur_mode_ff == CMC_CMD_NORMAL && !busy_ff) ? txd_ctrl_i : 1'b1; // RQ2 RQ4
      rxd_ctrl_o <= active_mode ? rxd_sync_ff[1] : 1'b1; // RQ3
    end
  end
endmodule : cmc_host

// ==== rtl/cmc_pkg.sv ====
// Package for the transceiver mode controller: register map, states, timing
package cmc_pkg;
  // APB register byte offsets
  localparam logic [7:0] CMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CMC_STAT_OFS = 8'h04;
  localparam logic [7:0] CMC_HOLD_OFS = 8'h08;
  // Control register fields
  localparam int CMC_CTRL_CMD_POS = 0;
  localparam int CMC_CTRL_GO_POS = 4;
  localparam int CMC_CTRL_CLRW_POS = 5;
  // Commanded operation modes
  localparam logic [2:0] CMC_CMD_NORMAL = 3'h1;
  localparam logic [2:0] CMC_CMD_RXONLY = 3'h2;
  localparam logic [2:0] CMC_CMD_STANDBY = 3'h3;
  localparam logic [2:0] CMC_CMD_SLEEP = 3'h4;
  // Timing: clock 10 MHz
  localparam int CMC_CLK_HZ = 10_000_000;
  localparam int CMC_HOLD_US = 50;
  localparam int CMC_HOLD_CYC = (CMC_HOLD_US * CMC_CLK_HZ + 999_999) / 1_000_000;
  localparam logic [15:0] CMC_HOLD_RST = 16'(CMC_HOLD_CYC);
  localparam logic [15:0] CMC_MARGIN_CYC = 16'h0002;
  // Controller states
  typedef enum logic [4:0] {
    CMC_IDLE = 5'b0_0001,
    CMC_STANDBY_CTRL_N_LOW = 5'b0_0010,
    CMC_HOLD = 5'b0_0100,
    CMC_EN_LOW = 5'b0_1000,
    CMC_DONE = 5'b1_0000
  } cmc_state_t;
endpackage : cmc_pkg
